// ==== rtl/page_reset_power_pkg.sv ====
package page_reset_power_pkg;

    // register offsets
    localparam logic [7:0] PAGE_SELECT_OFS = 8'h00;
    localparam logic [7:0] SOFT_RESET_CTRL_OFS = 8'h01;
    localparam logic [7:0] SLEEP_SUPPLY_CFG_OFS = 8'h02;
    localparam logic [7:0] SHUTDOWN_CFG_OFS = 8'h05;
    localparam logic [7:0] PAGE_ZERO = 8'h00;

    // reset values
    localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
    localparam logic [7:0] SLEEP_SUPPLY_CFG_RST = 8'h00;
    localparam logic [7:0] SHUTDOWN_CFG_RST = 8'h05;

    // field positions
    localparam int SOFT_RESET_BIT = 0;
    localparam int ANALOG_SUPPLY_SRC_BIT = 7;
    localparam int SLEEP_RSVD_HI = 6;
    localparam int SLEEP_RSVD_LO = 5;
    localparam int REF_FASTCHARGE_HI = 4;
    localparam int REF_FASTCHARGE_LO = 3;
    localparam int BROADCAST_ADDR_EN_BIT = 2;
    localparam int WAKE_N_SLEEP_BIT = 0;
    localparam int INPUT_FASTCHARGE_HI = 5;
    localparam int INPUT_FASTCHARGE_LO = 4;
    localparam int SHUTDOWN_BEHAVIOUR_HI = 3;
    localparam int SHUTDOWN_BEHAVIOUR_LO = 2;
    localparam int KEEPALIVE_HI = 1;
    localparam int KEEPALIVE_LO = 0;

    // shutdown behaviour codes
    localparam logic [1:0] SHDN_IMMEDIATE = 2'h0;
    localparam logic [1:0] SHDN_TIMEOUT = 2'h1;
    localparam logic [1:0] SHDN_CLEAN = 2'h2;

    // control bus addressing
    localparam logic [6:0] BROADCAST_ADDR = 7'h4c;
    localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2a; // arbitrary value

    // timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int TMR_W = 22;
    localparam int unsigned REF_QC_US0 = 3500;
    localparam int unsigned REF_QC_US1 = 10000;
    localparam int unsigned REF_QC_US2 = 50000;
    localparam int unsigned REF_QC_US3 = 100000;
    localparam int unsigned IN_QC_US0 = 2500;
    localparam int unsigned IN_QC_US1 = 12500;
    localparam int unsigned IN_QC_US2 = 25000;
    localparam int unsigned IN_QC_US3 = 50000;
    localparam int unsigned KA_US0 = 30000;
    localparam int unsigned KA_US1 = 25000;
    localparam int unsigned KA_US2 = 10000;
    localparam int unsigned KA_US3 = 5000;
    localparam logic [21:0] REF_QC_CYC0 = 22'(REF_QC_US0 * CYC_PER_US);
    localparam logic [21:0] REF_QC_CYC1 = 22'(REF_QC_US1 * CYC_PER_US);
    localparam logic [21:0] REF_QC_CYC2 = 22'(REF_QC_US2 * CYC_PER_US);
    localparam logic [21:0] REF_QC_CYC3 = 22'(REF_QC_US3 * CYC_PER_US);
    localparam logic [21:0] IN_QC_CYC0 = 22'(IN_QC_US0 * CYC_PER_US);
    localparam logic [21:0] IN_QC_CYC1 = 22'(IN_QC_US1 * CYC_PER_US);
    localparam logic [21:0] IN_QC_CYC2 = 22'(IN_QC_US2 * CYC_PER_US);
    localparam logic [21:0] IN_QC_CYC3 = 22'(IN_QC_US3 * CYC_PER_US);
    localparam logic [21:0] KA_CYC0 = 22'(KA_US0 * CYC_PER_US);
    localparam logic [21:0] KA_CYC1 = 22'(KA_US1 * CYC_PER_US);
    localparam logic [21:0] KA_CYC2 = 22'(KA_US2 * CYC_PER_US);
    localparam logic [21:0] KA_CYC3 = 22'(KA_US3 * CYC_PER_US);

endpackage

// ==== rtl/page_reset_power_cfg_regs.sv ====
`timescale 1ns/10ps
module page_reset_power_cfg_regs #(
    parameter logic [6:0] DEV_ADDR = page_reset_power_pkg::DEFAULT_DEV_ADDR,
    parameter logic [21:0] REF_QC_CYC [4] = '{page_reset_power_pkg::REF_QC_CYC0,
        page_reset_power_pkg::REF_QC_CYC1, page_reset_power_pkg::REF_QC_CYC2,
        page_reset_power_pkg::REF_QC_CYC3},
    parameter logic [21:0] IN_QC_CYC [4] = '{page_reset_power_pkg::IN_QC_CYC0,
        page_reset_power_pkg::IN_QC_CYC1, page_reset_power_pkg::IN_QC_CYC2,
        page_reset_power_pkg::IN_QC_CYC3},
    parameter logic [21:0] KA_CYC [4] = '{page_reset_power_pkg::KA_CYC0,
        page_reset_power_pkg::KA_CYC1, page_reset_power_pkg::KA_CYC2,
        page_reset_power_pkg::KA_CYC3}
) (
    input wire logic sys_clk_i, // 25 MHz system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic ce_i, // clock enable, freezes state when low
    input wire logic scl_i, // control bus clock
    input wire logic sda_i, // control bus data in
    output logic sda_o, // control bus data out, always low
    output logic sda_oe_o, // high while pulling data low
    input wire logic shutdown_pin_n_i, // shutdown pin, active low
    input wire logic clean_done_i, // clean shutdown sequence finished
    output logic [7:0] page_o, // selected page
    output logic sleep_o, // device held in sleep
    output logic analog_reg_en_o, // on-chip analog regulator enabled
    output logic broadcast_o, // broadcast addressing active
    output logic ref_fastcharge_o, // reference fast-charge phase active
    output logic input_fastcharge_o, // input fast-charge phase active
    output logic dig_reg_en_o // digital regulator enabled
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } bus_state_e;

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    bus_state_e state_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] ptr_q;
    logic rnw_q, oe_q, nack_q;
    logic wr_en;
    logic [7:0] page_q, sleep_cfg_q, shutdown_cfg_q, rd_byte;
    logic soft_rst_q;
    logic wake_q, pin_q;
    logic digital_regulator_on_q;
    logic [2:0] tmr_start, tmr_active, tmr_done;
    logic [21:0] tmr_len [3];
    logic addr_match;

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [21:0] pick_len(input logic [21:0] tbl [4],
                                             input logic [1:0] code);
        pick_len = tbl[code];
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] adr, input logic [7:0] pg,
                                            input logic [7:0] slp, input logic [7:0] shd);
        read_reg = 8'h00;
        if (adr == page_reset_power_pkg::PAGE_SELECT_OFS) begin
            read_reg = pg;
        end else if (pg == page_reset_power_pkg::PAGE_ZERO) begin
            case (adr)
                page_reset_power_pkg::SLEEP_SUPPLY_CFG_OFS: read_reg = slp;
                page_reset_power_pkg::SHUTDOWN_CFG_OFS: read_reg = shd;
                default: read_reg = 8'h00;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // control bus slave

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce_i) begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_det = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_det = scl_i & scl_q & ~sda_q & sda_i;
    // broadcast replaces the normal address rather than adding to it
    assign addr_match = sleep_cfg_q[page_reset_power_pkg::BROADCAST_ADDR_EN_BIT] ?
        (shift_q[7:1] == page_reset_power_pkg::BROADCAST_ADDR) :
        (shift_q[7:1] == DEV_ADDR);
    assign wr_en = scl_fall && state_q == ST_WR && bit_cnt_q == 4'h8;
    assign rd_byte = read_reg(ptr_q, page_q, sleep_cfg_q, shutdown_cfg_q);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            ptr_q <= 8'h00;
            rnw_q <= 1'b0;
            oe_q <= 1'b0;
            nack_q <= 1'b0;
        end else if (ce_i) begin
            if (start_det) begin
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                oe_q <= 1'b0;
            end else if (stop_det) begin
                state_q <= ST_IDLE;
                oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WR) begin
                    shift_q <= {shift_q[6:0], sda_i};
                    bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
                end else if (state_q == ST_RD_ACK) begin
                    nack_q <= sda_i;
                end
            end else if (scl_fall) begin
                case (state_q)
                    ST_ADDR: begin
                        if (bit_cnt_q == 4'h8) begin
                            if (addr_match) begin
                                oe_q <= 1'b1;
                                rnw_q <= shift_q[0];
                                state_q <= ST_ADDR_ACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        bit_cnt_q <= 4'h0;
                        if (rnw_q) begin
                            shift_q <= rd_byte;
                            oe_q <= ~rd_byte[7];
                            state_q <= ST_RD;
                        end else begin
                            oe_q <= 1'b0;
                            state_q <= ST_PTR;
                        end
                    end
                    ST_PTR: begin
                        if (bit_cnt_q == 4'h8) begin
                            ptr_q <= shift_q;
                            oe_q <= 1'b1;
                            state_q <= ST_PTR_ACK;
                        end
                    end
                    ST_WR: begin
                        if (bit_cnt_q == 4'h8) begin
                            ptr_q <= 8'(ptr_q + 8'h01);
                            oe_q <= 1'b1;
                            state_q <= ST_WR_ACK;
                        end
                    end
                    ST_PTR_ACK, ST_WR_ACK: begin
                        oe_q <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q <= ST_WR;
                    end
                    ST_RD: begin
                        if (bit_cnt_q == 4'h7) begin
                            oe_q <= 1'b0;
                            ptr_q <= 8'(ptr_q + 8'h01);
                            state_q <= ST_RD_ACK;
                        end else begin
                            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
                            shift_q <= {shift_q[6:0], 1'b0};
                            oe_q <= ~shift_q[6];
                        end
                    end
                    ST_RD_ACK: begin
                        if (nack_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            bit_cnt_q <= 4'h0;
                            shift_q <= rd_byte;
                            oe_q <= ~rd_byte[7];
                            state_q <= ST_RD;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file

    // soft reset takes effect one cycle after the write, so the ack is not cut
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst_q <= 1'b0;
        end else if (ce_i) begin
            soft_rst_q <= wr_en && page_q == page_reset_power_pkg::PAGE_ZERO &&
                ptr_q == page_reset_power_pkg::SOFT_RESET_CTRL_OFS &&
                shift_q[page_reset_power_pkg::SOFT_RESET_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= page_reset_power_pkg::PAGE_SELECT_RST;
            sleep_cfg_q <= page_reset_power_pkg::SLEEP_SUPPLY_CFG_RST;
            shutdown_cfg_q <= page_reset_power_pkg::SHUTDOWN_CFG_RST;
        end else if (ce_i) begin
            if (soft_rst_q) begin
                page_q <= page_reset_power_pkg::PAGE_SELECT_RST;
                sleep_cfg_q <= page_reset_power_pkg::SLEEP_SUPPLY_CFG_RST;
                shutdown_cfg_q <= page_reset_power_pkg::SHUTDOWN_CFG_RST;
            end else if (wr_en) begin
                if (ptr_q == page_reset_power_pkg::PAGE_SELECT_OFS) begin
                    page_q <= shift_q;
                end else if (page_q == page_reset_power_pkg::PAGE_ZERO) begin
                    if (ptr_q == page_reset_power_pkg::SLEEP_SUPPLY_CFG_OFS) begin
                        sleep_cfg_q <= {shift_q[7:2], 1'b0, shift_q[0]};
                    end
                    if (ptr_q == page_reset_power_pkg::SHUTDOWN_CFG_OFS) begin
                        shutdown_cfg_q <= {2'h0, shift_q[5:0]};
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timed phases

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wake_q <= 1'b0;
            pin_q <= 1'b1;
        end else if (ce_i) begin
            wake_q <= sleep_cfg_q[page_reset_power_pkg::WAKE_N_SLEEP_BIT];
            pin_q <= shutdown_pin_n_i;
        end
    end

    // both fast-charge phases start as the device leaves sleep
    assign tmr_start[0] = sleep_cfg_q[page_reset_power_pkg::WAKE_N_SLEEP_BIT] & ~wake_q;
    assign tmr_start[1] = tmr_start[0];
    assign tmr_start[2] = pin_q & ~shutdown_pin_n_i & shutdown_cfg_q[3:2] ==
        page_reset_power_pkg::SHDN_TIMEOUT;
    assign tmr_len[0] = pick_len(REF_QC_CYC, sleep_cfg_q[4:3]);
    assign tmr_len[1] = pick_len(IN_QC_CYC, shutdown_cfg_q[5:4]);
    assign tmr_len[2] = pick_len(KA_CYC, shutdown_cfg_q[1:0]);

    for (genvar i = 0; i < 3; i++) begin : g_tmr
        logic [21:0] cnt_q;
        always_ff @(posedge sys_clk_i or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q <= 22'h000000;
            end else if (ce_i) begin
                if (tmr_start[i]) begin
                    cnt_q <= tmr_len[i];
                end else if (cnt_q != 22'h000000) begin
                    cnt_q <= 22'(cnt_q - 22'h000001);
                end
            end
        end
        assign tmr_active[i] = cnt_q != 22'h000000;
        assign tmr_done[i] = cnt_q == 22'h000001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // digital regulator under shutdown

    // code 3 can be written; it falls to immediate power-down
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            digital_regulator_on_q <= 1'b1;
        end else if (ce_i) begin
            if (shutdown_pin_n_i) begin
                digital_regulator_on_q <= 1'b1;
            end else if (pin_q) begin
                case (shutdown_cfg_q[3:2])
                    page_reset_power_pkg::SHDN_TIMEOUT: digital_regulator_on_q <= 1'b1;
                    page_reset_power_pkg::SHDN_CLEAN: digital_regulator_on_q <= 1'b1;
                    default: digital_regulator_on_q <= 1'b0;
                endcase
            end else if (clean_done_i) begin
                digital_regulator_on_q <= 1'b0;
            end else if (tmr_done[2]) begin
                digital_regulator_on_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign sda_o = 1'b0;
    assign sda_oe_o = oe_q;
    assign page_o = page_q;
    assign sleep_o = ~sleep_cfg_q[page_reset_power_pkg::WAKE_N_SLEEP_BIT];
    assign analog_reg_en_o = sleep_cfg_q[page_reset_power_pkg::ANALOG_SUPPLY_SRC_BIT];
    assign broadcast_o = sleep_cfg_q[page_reset_power_pkg::BROADCAST_ADDR_EN_BIT];
    assign ref_fastcharge_o = tmr_active[0];
    assign input_fastcharge_o = tmr_active[1];
    assign dig_reg_en_o = digital_regulator_on_q;

endmodule

// ==== verification/cfg_regs_checker.sv ====
`timescale 1ns/10ps
module cfg_regs_checker #(
    parameter logic [21:0] REF_QC_CYC [4] = '{22'h1, 22'h1, 22'h1, 22'h1},
    parameter logic [21:0] IN_QC_CYC [4] = '{22'h1, 22'h1, 22'h1, 22'h1}
) (
    input wire logic sys_clk_i, // clock
    input wire logic nrst_i, // reset, active low
    input wire logic ce_i, // clock enable
    input wire logic scl_i, // bus clock
    input wire logic sda_i, // bus data in
    input wire logic sda_o, // bus data out
    input wire logic sda_oe_o, // bus pull enable
    input wire logic shutdown_pin_n_i, // shutdown pin
    input wire logic clean_done_i, // clean shutdown done
    input wire logic [7:0] page_o, // page
    input wire logic sleep_o, // sleep
    input wire logic analog_reg_en_o, // analog regulator
    input wire logic broadcast_o, // broadcast
    input wire logic ref_fastcharge_o, // ref charge
    input wire logic input_fastcharge_o, // input charge
    input wire logic dig_reg_en_o // digital regulator
);
    logic [21:0] ref_run_q;
    logic [21:0] in_run_q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // run lengths of the charge phases, bounded by the longest code
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_run_q <= 22'h0;
            in_run_q <= 22'h0;
        end else begin
            ref_run_q <= ref_fastcharge_o ? ref_run_q + 22'h1 : 22'h0;
            in_run_q <= input_fastcharge_o ? in_run_q + 22'h1 : 22'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    AST_RESET_VALUES: assert property ($rose(nrst_i) |-> page_o == 8'h00 && sleep_o
        && dig_reg_en_o) else $error("outputs not at reset values");
    AST_PAGE_SYNC: assert property ($changed(page_o) |-> !scl_i)
        else $error("page changed while bus clock high");
    AST_CFG_SYNC: assert property ($changed({sleep_o, analog_reg_en_o, broadcast_o})
        |-> !scl_i) else $error("config changed while bus clock high");
    AST_WAKE_CHARGE: assert property ($fell(sleep_o) |-> ##[0:2]
        (ref_fastcharge_o && input_fastcharge_o)) else $error("no charge phase on wake");
    AST_REF_CHARGE_MAX: assert property (ref_run_q <= REF_QC_CYC[3] + 22'h2)
        else $error("reference charge too long");
    AST_IN_CHARGE_MAX: assert property (in_run_q <= IN_QC_CYC[3] + 22'h2)
        else $error("input charge too long");
    AST_DIGITAL_REGULATOR_OFF_CAUSE: assert property ($fell(dig_reg_en_o) |-> !$past(shutdown_pin_n_i))
        else $error("regulator off without shutdown");
    AST_DIGITAL_REGULATOR_RESTORE: assert property ($rose(shutdown_pin_n_i) |-> ##[1:2] dig_reg_en_o)
        else $error("regulator not back after shutdown");
    AST_BUS_DRIVE: assert property ($changed(sda_oe_o) |-> !scl_i && sda_o == 1'b0)
        else $error("data driven off the low clock phase");
    COV_WAKE: cover property ($fell(sleep_o));
    COV_DIGITAL_REGULATOR_OFF: cover property ($fell(dig_reg_en_o));
    COV_PAGE: cover property ($changed(page_o));
endmodule
bind page_reset_power_cfg_regs cfg_regs_checker #(.REF_QC_CYC(REF_QC_CYC),
    .IN_QC_CYC(IN_QC_CYC)) u_checker (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .shutdown_pin_n_i(shutdown_pin_n_i), .clean_done_i(clean_done_i), .page_o(page_o),
    .sleep_o(sleep_o), .analog_reg_en_o(analog_reg_en_o), .broadcast_o(broadcast_o),
    .ref_fastcharge_o(ref_fastcharge_o), .input_fastcharge_o(input_fastcharge_o),
    .dig_reg_en_o(dig_reg_en_o));

// ==== verification/ctrl_bus_host.sv ====
`timescale 1ns/10ps
module ctrl_bus_host (
    input wire logic clk_i, // system clock
    input wire logic sda_i, // resolved data line
    output logic scl_o, // bus clock
    output logic sda_o // low pulls data, high releases
);
    // half step in clocks; raise to play a slow host
    int half = 2;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        tick(half);
        scl_o = 1'b1;
        tick(2 * half);
        r = sda_i;
        scl_o = 1'b0;
        tick(half);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic hack, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(hack, ack);
    endtask
    task automatic start();
        sda_o = 1'b1;
        tick(half);
        scl_o = 1'b1;
        tick(2 * half);
        sda_o = 1'b0;
        tick(2 * half);
        scl_o = 1'b0;
        tick(half);
    endtask
    task automatic stop();
        sda_o = 1'b0;
        tick(half);
        scl_o = 1'b1;
        tick(2 * half);
        sda_o = 1'b1;
        tick(2 * half);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
        output logic ok);
        logic [7:0] rx;
        logic k0, k1, k2;
        start();
        xfer({a, 1'b0}, 1'b1, rx, k0);
        xfer(p, 1'b1, rx, k1);
        xfer(d, 1'b1, rx, k2);
        stop();
        ok = !(k0 | k1 | k2);
    endtask
    // single-byte read; the host ends it with a nack
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
        output logic ok);
        logic [7:0] rx;
        logic k0, k1, k2, kn;
        start();
        xfer({a, 1'b0}, 1'b1, rx, k0);
        xfer(p, 1'b1, rx, k1);
        start();
        xfer({a, 1'b1}, 1'b1, rx, k2);
        xfer(8'hff, 1'b1, d, kn);
        stop();
        ok = !(k0 | k1 | k2);
    endtask
endmodule

// ==== verification/test_page_reset_power_cfg_regs.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end
module test_page_reset_power_cfg_regs;
    localparam logic [21:0] REF_C [4] = '{22'h0a, 22'h14, 22'h1e, 22'h28};
    localparam logic [21:0] IN_C [4] = '{22'h0c, 22'h16, 22'h20, 22'h2a};
    localparam logic [21:0] KA_C [4] = '{22'h32, 22'h3c, 22'h46, 22'h50};
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic shdn_n = 1'b1;
    logic clean_done = 1'b0;
    logic [6:0] addr = page_reset_power_pkg::DEFAULT_DEV_ADDR;
    logic [21:0] n_ref = 22'h0;
    logic [21:0] n_in = 22'h0;
    int bad_count = 0;
    int total_checks = 0;
    wire scl, host_sda, sda_line, sda_o, sda_oe, sleep, analog_supply_rail, bcast, refc, inc, digital_regulator;
    wire [7:0] page;
    // open drain with pull-up: high unless someone pulls
    assign sda_line = host_sda & (sda_oe ? sda_o : 1'b1);
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_ref <= n_ref + {21'h0, refc === 1'b1};
        n_in <= n_in + {21'h0, inc === 1'b1};
    end
    ctrl_bus_host u_host (.clk_i(sys_clk), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));
    page_reset_power_cfg_regs #(.REF_QC_CYC(REF_C), .IN_QC_CYC(IN_C), .KA_CYC(KA_C)) u_dut (
        .sys_clk_i(sys_clk), .nrst_i(nrst), .ce_i(1'b1), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .shutdown_pin_n_i(shdn_n), .clean_done_i(clean_done),
        .page_o(page), .sleep_o(sleep), .analog_reg_en_o(analog_supply_rail), .broadcast_o(bcast),
        .ref_fastcharge_o(refc), .input_fastcharge_o(inc), .dig_reg_en_o(digital_regulator));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        u_host.wr(addr, p, d, ok);
        `CHK("write ack", 1'b1, ok)
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] v;
        logic ok;
        u_host.rd(addr, p, v, ok);
        `CHK("read ack", 1'b1, ok)
        `CHK("readback", e, v)
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("sleep", 1'b1, sleep)
        `CHK("digital_regulator", 1'b1, digital_regulator)
        `CHK("analog_supply_rail", 1'b0, analog_supply_rail)
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h05, 8'h05);
    endtask
    task automatic t_charge();
        logic [21:0] r0, i0;
        for (int c = 0; c < 4; c++) begin
            wr(8'h05, {2'b00, 2'(c), 4'b0101});
            r0 = n_ref;
            i0 = n_in;
            wr(8'h02, {3'b000, 2'(c), 3'b001});
            tick(60);
            `CHK("ref charge", REF_C[c], 22'(n_ref - r0))
            `CHK("input charge", IN_C[c], 22'(n_in - i0))
            `CHK("awake", 1'b0, sleep)
            rd_chk(8'h02, {3'b000, 2'(c), 3'b001});
            rd_chk(8'h05, {2'b00, 2'(c), 4'b0101});
            wr(8'h02, 8'h00);
            `CHK("asleep", 1'b1, sleep)
        end
    endtask
    task automatic t_bcast();
        logic [7:0] v;
        logic ok;
        wr(8'h02, 8'h84);
        `CHK("analog_supply_rail on", 1'b1, analog_supply_rail)
        `CHK("bcast on", 1'b1, bcast)
        u_host.rd(addr, 8'h02, v, ok);
        `CHK("normal addr refused", 1'b0, ok)
        addr = 7'h4c;
        rd_chk(8'h02, 8'h84);
        wr(8'h02, 8'h00);
        addr = page_reset_power_pkg::DEFAULT_DEV_ADDR;
        `CHK("bcast off", 1'b0, bcast)
        rd_chk(8'h02, 8'h00);
    endtask
    task automatic t_page();
        u_host.half = 5;
        wr(8'h00, 8'hff);
        `CHK("page", 8'hff, page)
        wr(8'h02, 8'h80);
        `CHK("ignored off page", 1'b0, analog_supply_rail)
        rd_chk(8'h00, 8'hff);
        rd_chk(8'h02, 8'h00);
        wr(8'h00, 8'h00);
        `CHK("page back", 8'h00, page)
        u_host.half = 2;
    endtask
    task automatic t_soft();
        wr(8'h02, 8'h81);
        wr(8'h05, 8'h28);
        wr(8'h01, 8'h01);
        `CHK("sleep after reset", 1'b1, sleep)
        `CHK("analog_supply_rail after reset", 1'b0, analog_supply_rail)
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h05, 8'h05);
    endtask
    task automatic t_shdn();
        int n;
        for (int k = 0; k < 4; k++) begin
            wr(8'h05, {6'b000001, 2'(k)});
            shdn_n = 1'b0;
            n = 0;
            while (digital_regulator === 1'b1 && n < 200) begin
                tick(1);
                n++;
            end
            `CHK("keepalive", 1'b1, n >= int'(KA_C[k]) && n <= int'(KA_C[k]) + 3)
            shdn_n = 1'b1;
            tick(3);
            `CHK("digital_regulator back", 1'b1, digital_regulator)
        end
        wr(8'h05, 8'h00);
        shdn_n = 1'b0;
        tick(3);
        `CHK("digital_regulator immediate", 1'b0, digital_regulator)
        shdn_n = 1'b1;
        tick(3);
        wr(8'h05, 8'h08);
        shdn_n = 1'b0;
        tick(120);
        `CHK("digital_regulator held", 1'b1, digital_regulator)
        clean_done = 1'b1;
        tick(1);
        clean_done = 1'b0;
        tick(3);
        `CHK("digital_regulator after clean", 1'b0, digital_regulator)
        shdn_n = 1'b1;
        tick(3);
        wr(8'h05, 8'h05);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        tick(3);
        t_reset();
        t_charge();
        t_bcast();
        t_page();
        t_soft();
        t_shdn();
        conclude();
    end
    // whole run needs some 16k clocks
    initial begin
        repeat (80000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
endmodule
